// ### hdl/irq_output_formatter.sv
`timescale 1ns/100ps
`default_nettype none
module irq_output_formatter #(
	parameter int PULSE_CYCLES = fmt_pkg::PULSE_CYCLES,
	parameter int PERIOD_CYCLES = fmt_pkg::PERIOD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fmt_pkg::ADDR_W-1:0] paddr,
	input wire logic [fmt_pkg::DATA_W-1:0] pwdata,
	output logic [fmt_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dspEvent,
	input wire logic overcurrentEvent,
	input wire logic agcEvent,
	output logic firstIrqOut,
	output logic secondIrqOut
);
	localparam int NO = fmt_pkg::NUM_OUT;
	localparam int NS = fmt_pkg::NUM_SRC;
	localparam int CW = fmt_pkg::CNT_W;
	localparam int IW = fmt_pkg::IDX_W;
	localparam int DW = fmt_pkg::DATA_W;
	localparam logic [CW-1:0] PULSE_LEN = CW'(PULSE_CYCLES);
	localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYCLES - 1);
	localparam logic [CW-1:0] PERIOD_LEN = CW'(PERIOD_CYCLES);
	localparam logic [CW-1:0] PERIOD_LAST = CW'(PERIOD_CYCLES - 1);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);

	typedef struct packed {
		logic [NO-1:0][fmt_pkg::FMT_W-1:0] fmt;
		logic [NO-1:0][NS-1:0] en;
		logic [NS-1:0] sticky;
		logic [NS-1:0] liveDly;
		logic [NO-1:0] active;
		logic [NO-1:0][CW-1:0] cnt;
		logic [NO-1:0] irq;
		logic [DW-1:0] rdata;
	} state_t;

	state_t state_ff;
	state_t nxt_state;

	logic [NS-1:0] live;
	logic [NS-1:0] rise;
	logic [NS-1:0] clr;
	logic [NO-1:0] trig;
	logic [IW-1:0] idx;
	logic mapped;
	logic setup;
	logic access;
	logic wrAcc;
	logic rdAcc;
	logic flagRd;
	logic fmtWr;

	function automatic logic [NS-1:0] flagHit(input logic [IW-1:0] a);
		flagHit = '0;
		case (a)
			fmt_pkg::IDX_DSP_FLAG: flagHit[fmt_pkg::SRC_DSP] = 1'b1;
			fmt_pkg::IDX_OC_FLAG: flagHit[fmt_pkg::SRC_OC] = 1'b1;
			fmt_pkg::IDX_AGC_FLAG: flagHit[fmt_pkg::SRC_AGC] = 1'b1;
			default: flagHit = '0;
		endcase
	endfunction

	function automatic logic isMapped(input logic [IW-1:0] a);
		case (a)
			fmt_pkg::IDX_DSP_FLAG, fmt_pkg::IDX_OC_FLAG, fmt_pkg::IDX_AGC_FLAG,
			fmt_pkg::IDX_EN_FIRST, fmt_pkg::IDX_EN_SECOND,
			fmt_pkg::IDX_FORMAT: isMapped = 1'b1;
			default: isMapped = 1'b0;
		endcase
	endfunction

	function automatic logic [IW-1:0] enIdx(input int o);
		enIdx = (o == 0) ? fmt_pkg::IDX_EN_FIRST : fmt_pkg::IDX_EN_SECOND;
	endfunction

	function automatic logic [DW-1:0] enWord(input logic [NS-1:0] e);
		enWord = '0;
		enWord[fmt_pkg::EN_DSP_BIT] = e[fmt_pkg::SRC_DSP];
		enWord[fmt_pkg::EN_OC_BIT] = e[fmt_pkg::SRC_OC];
		enWord[fmt_pkg::EN_AGC_BIT] = e[fmt_pkg::SRC_AGC];
	endfunction

	function automatic logic [DW-1:0] readValue(input logic [IW-1:0] a, input state_t s,
			input logic [NS-1:0] lv);
		logic [NS-1:0] hit;
		readValue = '0;
		hit = flagHit(a);
		for (int k = 0; k < NS; k++) begin
			if (hit[k]) begin
				readValue[fmt_pkg::FLAG_STICKY_BIT] = s.sticky[k];
				readValue[fmt_pkg::FLAG_LIVE_BIT] = lv[k];
			end
		end
		for (int o = 0; o < NO; o++) begin
			if (a == enIdx(o)) begin
				readValue = enWord(s.en[o]);
			end
		end
		if (a == fmt_pkg::IDX_FORMAT) begin
			// low nibble stays zero
			readValue[fmt_pkg::FMT_FIRST_LSB +: fmt_pkg::FMT_W] = s.fmt[0];
			readValue[fmt_pkg::FMT_SECOND_LSB +: fmt_pkg::FMT_W] = s.fmt[1];
		end
	endfunction

	// event sources come from logic on this same clock
	assign live = {agcEvent, overcurrentEvent, dspEvent};
	assign rise = live & ~state_ff.liveDly;
	assign idx = paddr[fmt_pkg::ADDR_W-1:fmt_pkg::LANE_W];
	assign mapped = isMapped(idx) && (paddr[fmt_pkg::LANE_W-1:0] == 2'h0);
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wrAcc = access & pwrite & mapped;
	assign rdAcc = access & ~pwrite & mapped;
	assign flagRd = rdAcc & (|flagHit(idx));
	assign fmtWr = wrAcc & (idx == fmt_pkg::IDX_FORMAT);
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = state_ff.rdata;
	assign firstIrqOut = state_ff.irq[0];
	assign secondIrqOut = state_ff.irq[1];

	always_comb begin
		nxt_state = state_ff;
		nxt_state.liveDly = live;
		if (setup) begin
			nxt_state.rdata = mapped ? readValue(idx, state_ff, live) : '0;
		end
		// clear only what the master was shown, so an event landing between
		// setup and access survives; a fresh event wins over the clear
		clr = '0;
		if (rdAcc) begin
			clr = flagHit(idx) & {NS{state_ff.rdata[fmt_pkg::FLAG_STICKY_BIT]}};
		end
		nxt_state.sticky = (state_ff.sticky & ~clr) | live;
		if (fmtWr) begin
			nxt_state.fmt[0] = pwdata[fmt_pkg::FMT_FIRST_LSB +: fmt_pkg::FMT_W];
			nxt_state.fmt[1] = pwdata[fmt_pkg::FMT_SECOND_LSB +: fmt_pkg::FMT_W];
		end
		trig = '0;
		for (int o = 0; o < NO; o++) begin
			if (wrAcc && idx == enIdx(o)) begin
				nxt_state.en[o][fmt_pkg::SRC_DSP] = pwdata[fmt_pkg::EN_DSP_BIT];
				nxt_state.en[o][fmt_pkg::SRC_OC] = pwdata[fmt_pkg::EN_OC_BIT];
				nxt_state.en[o][fmt_pkg::SRC_AGC] = pwdata[fmt_pkg::EN_AGC_BIT];
			end
			trig[o] = |(nxt_state.en[o] & rise);
			if (fmtWr) begin
				nxt_state.active[o] = 1'b0;
				nxt_state.cnt[o] = '0;
			end else if (state_ff.active[o]) begin
				case (nxt_state.fmt[o])
					fmt_pkg::FMT_SINGLE: begin
						if (state_ff.cnt[o] == PULSE_LAST) begin
							nxt_state.active[o] = 1'b0;
						end else begin
							nxt_state.cnt[o] = state_ff.cnt[o] + CNT_ONE;
						end
					end
					fmt_pkg::FMT_TRAIN: begin
						if (state_ff.cnt[o] == PERIOD_LAST) begin
							nxt_state.cnt[o] = '0;
						end else begin
							nxt_state.cnt[o] = state_ff.cnt[o] + CNT_ONE;
						end
						if (flagRd && !trig[o]) begin
							nxt_state.active[o] = 1'b0;
						end
					end
					default: nxt_state.active[o] = 1'b0;
				endcase
			end
			// an event during a running pulse merges into it rather than stretching it
			if (trig[o] && (!state_ff.active[o] || fmtWr) &&
					(nxt_state.fmt[o] == fmt_pkg::FMT_SINGLE ||
					nxt_state.fmt[o] == fmt_pkg::FMT_TRAIN)) begin
				nxt_state.active[o] = 1'b1;
				nxt_state.cnt[o] = '0;
			end
			case (nxt_state.fmt[o])
				fmt_pkg::FMT_SINGLE: nxt_state.irq[o] = nxt_state.active[o];
				fmt_pkg::FMT_TRAIN: begin
					nxt_state.irq[o] = nxt_state.active[o] && (nxt_state.cnt[o] < PULSE_LEN);
				end
				fmt_pkg::FMT_STICKY: begin
					nxt_state.irq[o] = |(nxt_state.en[o] & nxt_state.sticky);
				end
				fmt_pkg::FMT_LIVE: nxt_state.irq[o] = |(nxt_state.en[o] & live);
				default: nxt_state.irq[o] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_ff <= '0;
			state_ff.fmt <= {NO{fmt_pkg::FMT_RESET}};
		end else begin
			state_ff <= nxt_state;
		end
	end

	// helper counters read only by the checks below
	logic [NO-1:0][CW-1:0] hiLen_ff;
	logic [NO-1:0][CW-1:0] riseGap_ff;
	logic [NO-1:0] irqDly_ff;

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			hiLen_ff <= '0;
			riseGap_ff <= '0;
			irqDly_ff <= '0;
		end else begin
			for (int o = 0; o < NO; o++) begin
				hiLen_ff[o] <= state_ff.irq[o] ? hiLen_ff[o] + CNT_ONE : '0;
				// restarts at each rising edge, so it holds the rise-to-rise distance
				riseGap_ff[o] <= (state_ff.irq[o] && !irqDly_ff[o]) ? CNT_ONE :
					riseGap_ff[o] + CNT_ONE;
				irqDly_ff[o] <= state_ff.irq[o];
			end
		end
	end

	a_single_width1: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(firstIrqOut) && state_ff.fmt[0] == fmt_pkg::FMT_SINGLE && !$past(fmtWr)
		|-> hiLen_ff[0] == PULSE_LEN)
		else $error("first output single pulse has wrong width");

	a_train_period: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(firstIrqOut) && state_ff.fmt[0] == fmt_pkg::FMT_TRAIN
		&& $past(state_ff.active[0]) |-> riseGap_ff[0] == PERIOD_LEN)
		else $error("first output train period is wrong");

	a_train_stop: assert property (@(posedge clk_sys) disable iff (reset)
		flagRd && !trig[0] && !fmtWr && state_ff.fmt[0] == fmt_pkg::FMT_TRAIN
		|=> !firstIrqOut && !state_ff.active[0])
		else $error("pulse train kept running after flag read");

	a_sticky_level: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[0] == fmt_pkg::FMT_STICKY
		|-> firstIrqOut == |(state_ff.en[0] & state_ff.sticky))
		else $error("first output does not follow sticky flags");

	a_live_level: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[0] == fmt_pkg::FMT_LIVE && !$past(reset)
		|-> firstIrqOut == |(state_ff.en[0] & $past(live)))
		else $error("first output does not follow live condition");

	a_single_width2: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(secondIrqOut) && state_ff.fmt[1] == fmt_pkg::FMT_SINGLE && !$past(fmtWr)
		|-> hiLen_ff[1] == PULSE_LEN)
		else $error("second output single pulse has wrong width");

	a_fmt_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(fmtWr) && !$past(reset) |-> state_ff.fmt == $past(state_ff.fmt))
		else $error("format field changed without a write");

	a_fmt_read: assert property (@(posedge clk_sys) disable iff (reset)
		setup && mapped && idx == fmt_pkg::IDX_FORMAT
		|=> prdata[fmt_pkg::FMT_SECOND_LSB-1:0] == '0
		&& prdata[fmt_pkg::FMT_FIRST_LSB +: fmt_pkg::FMT_W] == $past(state_ff.fmt[0]))
		else $error("format register read value is wrong");

	a_enable_gate: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[1] == fmt_pkg::FMT_LIVE && state_ff.en[1] == '0 |-> !secondIrqOut)
		else $error("disabled sources reach the second output");

	a_sticky_clear: assert property (@(posedge clk_sys) disable iff (reset)
		rdAcc && idx == fmt_pkg::IDX_DSP_FLAG && !live[fmt_pkg::SRC_DSP]
		&& state_ff.rdata[fmt_pkg::FLAG_STICKY_BIT]
		|=> !state_ff.sticky[fmt_pkg::SRC_DSP])
		else $error("sticky flag not cleared by its read");

	a_restart_cnt: assert property (@(posedge clk_sys) disable iff (reset)
		fmtWr && !trig[1] |=> !state_ff.active[1] && state_ff.cnt[1] == '0)
		else $error("format write did not restart the counter");

	a_restart_cnt1: assert property (@(posedge clk_sys) disable iff (reset)
		fmtWr && !trig[0] |=> !state_ff.active[0] && state_ff.cnt[0] == '0)
		else $error("format write did not restart the first counter");

	a_train_period2: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(secondIrqOut) && state_ff.fmt[1] == fmt_pkg::FMT_TRAIN
		&& $past(state_ff.active[1]) |-> riseGap_ff[1] == PERIOD_LEN)
		else $error("second output train period is wrong");

	a_train_high1: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(firstIrqOut) && state_ff.fmt[0] == fmt_pkg::FMT_TRAIN
		&& !$past(fmtWr) && !$past(flagRd)
		|-> hiLen_ff[0] == PULSE_LEN)
		else $error("first output train pulse has wrong width");

	a_train_high2: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(secondIrqOut) && state_ff.fmt[1] == fmt_pkg::FMT_TRAIN
		&& !$past(fmtWr) && !$past(flagRd)
		|-> hiLen_ff[1] == PULSE_LEN)
		else $error("second output train pulse has wrong width");

	a_train_stop2: assert property (@(posedge clk_sys) disable iff (reset)
		flagRd && !trig[1] && !fmtWr && state_ff.fmt[1] == fmt_pkg::FMT_TRAIN
		|=> !secondIrqOut && !state_ff.active[1])
		else $error("second pulse train kept running after flag read");

	a_sticky_level2: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[1] == fmt_pkg::FMT_STICKY
		|-> secondIrqOut == |(state_ff.en[1] & state_ff.sticky))
		else $error("second output does not follow sticky flags");

	a_live_level2: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[1] == fmt_pkg::FMT_LIVE && !$past(reset)
		|-> secondIrqOut == |(state_ff.en[1] & $past(live)))
		else $error("second output does not follow live condition");

	a_sticky_hold1: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[0] == fmt_pkg::FMT_STICKY && firstIrqOut && !flagRd && !fmtWr
		&& !(wrAcc && idx == fmt_pkg::IDX_EN_FIRST)
		|=> firstIrqOut)
		else $error("first sticky level dropped without a flag read");

	a_sticky_hold2: assert property (@(posedge clk_sys) disable iff (reset)
		state_ff.fmt[1] == fmt_pkg::FMT_STICKY && secondIrqOut && !flagRd && !fmtWr
		&& !(wrAcc && idx == fmt_pkg::IDX_EN_SECOND)
		|=> secondIrqOut)
		else $error("second sticky level dropped without a flag read");

	a_pulse_start1: assert property (@(posedge clk_sys) disable iff (reset)
		trig[0] && !state_ff.active[0] && !fmtWr
		&& state_ff.fmt[0] == fmt_pkg::FMT_SINGLE |=> firstIrqOut)
		else $error("first output missed a single pulse");

	a_pulse_start2: assert property (@(posedge clk_sys) disable iff (reset)
		trig[1] && !state_ff.active[1] && !fmtWr
		&& state_ff.fmt[1] == fmt_pkg::FMT_SINGLE |=> secondIrqOut)
		else $error("second output missed a single pulse");

endmodule
`default_nettype wire

// ### hdl/fmt_pkg.sv
// Functional notes
// - first output mode 00: one 2 ms pulse
// - first output train: 2ms high, 4ms period
// - first output train stops on flag register read
// - first output mode 10: level from sticky flags
// - first output mode 11: level follows live condition
// - second output mode 00: one 2 ms pulse
// - second output 01: pulse train until flag read
// - second output 10: sticky level, cleared by read
// - second output mode 11: level follows live condition
// - format fields D7-D6 and D5-D4, reset 00
// - format bits D3-D0 read zero, write zero
// - each output combines only its enabled sources
// - sticky flags clear when their register is read
package fmt_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int IDX_W = 6;
	localparam int LANE_W = 2;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_DSP_FLAG = 6'h2A;
	localparam logic [IDX_W-1:0] IDX_OC_FLAG = 6'h2C;
	localparam logic [IDX_W-1:0] IDX_AGC_FLAG = 6'h2D;
	localparam logic [IDX_W-1:0] IDX_EN_FIRST = 6'h30;
	localparam logic [IDX_W-1:0] IDX_EN_SECOND = 6'h31;
	localparam logic [IDX_W-1:0] IDX_FORMAT = 6'h33;
	localparam int FMT_W = 2;
	localparam int FMT_FIRST_LSB = 6;
	localparam int FMT_SECOND_LSB = 4;
	localparam logic [FMT_W-1:0] FMT_RESET = 2'h0;
	localparam logic [FMT_W-1:0] FMT_SINGLE = 2'h0;
	localparam logic [FMT_W-1:0] FMT_TRAIN = 2'h1;
	localparam logic [FMT_W-1:0] FMT_STICKY = 2'h2;
	localparam logic [FMT_W-1:0] FMT_LIVE = 2'h3;
	localparam int EN_DSP_BIT = 2;
	localparam int EN_OC_BIT = 3;
	localparam int EN_AGC_BIT = 4;
	localparam int FLAG_STICKY_BIT = 0;
	localparam int FLAG_LIVE_BIT = 1;
	localparam int SRC_DSP = 0;
	localparam int SRC_OC = 1;
	localparam int SRC_AGC = 2;
	localparam int NUM_SRC = 3;
	localparam int NUM_OUT = 2;
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	localparam int PULSE_MS = 2;
	localparam int PERIOD_MS = 4;
	localparam int PULSE_CYCLES = PULSE_MS * (CLK_HZ / MS_PER_S);
	localparam int PERIOD_CYCLES = PERIOD_MS * (CLK_HZ / MS_PER_S);
	localparam int CNT_W = 19;
endpackage

// ### test/irq_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module irq_host_model (
	input wire logic clk_sys,
	input wire logic irqLine,
	output logic [31:0] widthSeen,
	output logic widthDone,
	output logic [31:0] riseCount
);
	logic [31:0] runLen;
	logic lastLevel;
	initial begin
		runLen = 32'h0;
		lastLevel = 1'b0;
		widthSeen = 32'h0;
		widthDone = 1'b0;
		riseCount = 32'h0;
	end
	// the host only samples at its clock, so widths are whole cycles
	always @(posedge clk_sys) begin
		lastLevel <= irqLine;
		widthDone <= 1'b0;
		if (irqLine === 1'b1) begin
			runLen <= runLen + 32'h1;
			if (lastLevel !== 1'b1)
				riseCount <= riseCount + 32'h1;
		end else if (runLen != 32'h0) begin
			widthSeen <= runLen;
			widthDone <= 1'b1;
			runLen <= 32'h0;
		end
	end
endmodule
`default_nettype wire

// ### test/interrupt_output_formatter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module interrupt_output_formatter_tb;
	localparam logic [7:0] A_FMT = {fmt_pkg::IDX_FORMAT, 2'h0};
	localparam logic [7:0] A_EN1 = {fmt_pkg::IDX_EN_FIRST, 2'h0};
	localparam logic [7:0] A_EN2 = {fmt_pkg::IDX_EN_SECOND, 2'h0};
	localparam logic [7:0] A_DSP = {fmt_pkg::IDX_DSP_FLAG, 2'h0};
	localparam logic [7:0] A_OC = {fmt_pkg::IDX_OC_FLAG, 2'h0};
	localparam logic [7:0] A_AGC = {fmt_pkg::IDX_AGC_FLAG, 2'h0};
	logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, irq1, irq2, wd1, wd2;
	logic [7:0] paddr;
	logic [2:0] ev;
	logic [31:0] pwdata, prdata, wid1, wid2, rise1, rise2, rd, rdObs, n1, n2;
	logic err, watchW, b;
	int errors, checkCount;
	logic [31:0] expQ[$], wQ1[$], wQ2[$];
	event rdEvt;
	// short counts keep the run small; expectations use the same figures
	irq_output_formatter #(.PULSE_CYCLES(8), .PERIOD_CYCLES(16)) dut_u (.clk_sys(clk_sys),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.dspEvent(ev[0]), .overcurrentEvent(ev[1]), .agcEvent(ev[2]),
		.firstIrqOut(irq1), .secondIrqOut(irq2));
	irq_host_model hostFirst (.clk_sys(clk_sys), .irqLine(irq1), .widthSeen(wid1),
		.widthDone(wd1), .riseCount(rise1));
	irq_host_model hostSecond (.clk_sys(clk_sys), .irqLine(irq2), .widthSeen(wid2),
		.widthDone(wd2), .riseCount(rise2));
	always #5 clk_sys = ~clk_sys;
	task automatic testDone;
		$display("TB: checks=%0d errors=%0d", checkCount, errors);
		if (errors == 0 && checkCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			testDone();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		expQ.push_back(exp);
		rdObs = rd;
		->rdEvt;
	endtask
	task automatic waitCyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic pulse(input logic [2:0] v);
		@(posedge clk_sys);
		ev <= v;
		@(posedge clk_sys);
		ev <= 3'h0;
	endtask
	always @(rdEvt) check(rdObs, expQ.pop_front());
	always @(posedge clk_sys) begin
		if (watchW && wd1) check(wid1, wQ1.pop_front());
		if (watchW && wd2) check(wid2, wQ2.pop_front());
	end
	initial begin
		#500000;
		errors++;
		testDone();
	end
	initial begin
		clk_sys = 0; reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		ev = 0; watchW = 0; errors = 0; checkCount = 0;
		void'($urandom(32'h8FF8));
		repeat (10) @(posedge clk_sys);
		reset <= 1'b0;
		regRead(A_FMT, 32'h0);
		regRead(A_EN1, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, A_FMT, 32'hC0);
		regRead(A_FMT, 32'hC0);
		$display("TB: register map test done");
		apb(1'b1, A_EN1, 32'h04);
		apb(1'b1, A_EN2, 32'h08);
		apb(1'b1, A_FMT, 32'h00);
		watchW = 1'b1;
		wQ1.push_back(32'd8);
		pulse(3'b001);
		waitCyc(20);
		wQ2.push_back(32'd8);
		pulse(3'b010);
		waitCyc(20);
		n1 = rise1;
		n2 = rise2;
		pulse(3'b100);
		waitCyc(20);
		check(rise1, n1);
		check(rise2, n2);
		watchW = 1'b0;
		regRead(A_DSP, 32'h1);
		regRead(A_DSP, 32'h0);
		regRead(A_OC, 32'h1);
		$display("TB: single pulse test done");
		apb(1'b1, A_FMT, 32'h50);
		n1 = rise1;
		n2 = rise2;
		pulse(3'b011);
		waitCyc(40);
		check(rise1 - n1, 32'h3);
		check(rise2 - n2, 32'h3);
		regRead(A_DSP, 32'h1);
		waitCyc(2);
		n1 = rise1;
		n2 = rise2;
		waitCyc(40);
		check(rise1, n1);
		check(rise2, n2);
		$display("TB: pulse train test done");
		apb(1'b1, A_EN1, 32'h10);
		apb(1'b1, A_EN2, 32'h10);
		apb(1'b1, A_FMT, 32'hA0);
		pulse(3'b100);
		waitCyc(5);
		check(32'(irq1), 32'h1);
		check(32'(irq2), 32'h1);
		regRead(A_AGC, 32'h1);
		waitCyc(2);
		check(32'(irq1), 32'h0);
		check(32'(irq2), 32'h0);
		$display("TB: sticky level test done");
		apb(1'b1, A_FMT, 32'hF0);
		for (int i = 0; i < 8; i++) begin
			b = 1'($urandom % 2);
			ev <= {b, 2'b00};
			waitCyc(3);
			check(32'(irq1), 32'(b));
			check(32'(irq2), 32'(b));
		end
		// with its enables cleared the second output must ignore a live source
		apb(1'b1, A_EN2, 32'h0);
		ev <= 3'h4;
		waitCyc(3);
		check(32'(irq1), 32'h1);
		check(32'(irq2), 32'h0);
		ev <= 3'h0;
		$display("TB: live level test done");
		apb(1'b1, A_FMT, 32'h00);
		pulse(3'b100);
		waitCyc(2);
		check(32'(irq1), 32'h1);
		// a format write must cut the running pulse short
		apb(1'b1, A_FMT, 32'h00);
		waitCyc(1);
		check(32'(irq1), 32'h0);
		$display("TB: format restart test done");
		testDone();
	end
endmodule
`default_nettype wire
